// File: hw/dsp_ddr_sram.sv
`timescale 1ns/1ns
module dsp_ddr_sram #(
    parameter int AW = 10,
    parameter bit WIDE = 1'b1,
    parameter int LOCK_CYCLES = dsp_pkg::LOCK_CYCLES
) (
    // System clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Loop control, low bypasses the delay locked loop
    input wire logic dll_bypass_n,
    output logic dll_locked,
    // Link clock and commands
    input wire logic link_clk,
    input wire logic rd_sel_n,
    input wire logic wr_sel_n,
    input wire logic [AW-1:0] addr_in,
    // Write port
    input wire logic [dsp_pkg::DATA_W-1:0] wr_data_in,
    input wire logic [dsp_pkg::LANES-1:0] byte_mask_n,
    // Read port
    output logic [dsp_pkg::DATA_W-1:0] rd_data_out,
    output logic rd_data_oe,
    output logic out_valid_flag,
    output logic echo_out_clk,
    output logic echo_out_clk_inv
);

    localparam int DW = dsp_pkg::DATA_W;
    localparam int LW = dsp_pkg::LANE_W;
    localparam int LANES_USED = WIDE ? dsp_pkg::LANES : dsp_pkg::LANES / 2;
    localparam int MW = AW + 2;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Narrow parts keep the upper half at zero
    function automatic logic [DW-1:0] fit(input logic [DW-1:0] d);
        logic [DW-1:0] r;
        r = d;
        if (!WIDE) begin
            r[DW-1:dsp_pkg::NARROW_W] = '0;
        end
        return r;
    endfunction

    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
            input logic [DW-1:0] d, input logic [dsp_pkg::LANES-1:0] m_n);
        logic [DW-1:0] r;
        r = old;
        for (int i = 0; i < LANES_USED; i++) begin
            if (!m_n[i]) begin
                r[i*LW +: LW] = d[i*LW +: LW];
            end
        end
        return fit(r);
    endfunction

    function automatic logic [MW-1:0] loc(input logic [AW-1:0] a,
            input logic [1:0] beat);
        return {a, beat};
    endfunction

    // ------------------------------------------------------------
    // Loop lock timer, system clock domain
    // ------------------------------------------------------------
    logic [1:0] doff_sync_ff;
    logic [1:0] nxt_doff_sync;
    dsp_pkg::dsp_dll_state_t dll_state_ff;
    dsp_pkg::dsp_dll_state_t nxt_dll_state;
    logic [dsp_pkg::LOCK_CNT_W-1:0] lock_cnt_ff;
    logic [dsp_pkg::LOCK_CNT_W-1:0] nxt_lock_cnt;
    logic [dsp_pkg::LOCK_CNT_W-1:0] lock_last;

    assign lock_last = dsp_pkg::LOCK_CNT_W'(LOCK_CYCLES - 1);

    always_comb begin
        nxt_doff_sync = {doff_sync_ff[0], dll_bypass_n};
        nxt_dll_state = dll_state_ff;
        nxt_lock_cnt = lock_cnt_ff;
        case (dll_state_ff)
            dsp_pkg::DLL_BYPASS: begin
                nxt_lock_cnt = '0;
                if (doff_sync_ff[1]) begin
                    nxt_dll_state = dsp_pkg::DLL_LOCKING;
                end
            end
            dsp_pkg::DLL_LOCKING: begin
                if (!doff_sync_ff[1]) begin
                    nxt_dll_state = dsp_pkg::DLL_BYPASS;
                    nxt_lock_cnt = '0;
                end else if (lock_cnt_ff == lock_last) begin
                    nxt_dll_state = dsp_pkg::DLL_LOCKED;
                end else begin
                    nxt_lock_cnt = lock_cnt_ff + 1'b1;
                end
            end
            dsp_pkg::DLL_LOCKED: begin
                if (!doff_sync_ff[1]) begin
                    // Lock is forgotten; relocking counts from zero
                    nxt_dll_state = dsp_pkg::DLL_BYPASS;
                    nxt_lock_cnt = '0;
                end
            end
            default: begin
                nxt_dll_state = dsp_pkg::DLL_BYPASS;
                nxt_lock_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            doff_sync_ff <= dsp_pkg::SYNC_RST;
            dll_state_ff <= dsp_pkg::DLL_BYPASS;
            lock_cnt_ff <= '0;
        end else begin
            doff_sync_ff <= nxt_doff_sync;
            dll_state_ff <= nxt_dll_state;
            lock_cnt_ff <= nxt_lock_cnt;
        end
    end

    assign dll_locked = (dll_state_ff == dsp_pkg::DLL_LOCKED);

    // ------------------------------------------------------------
    // Link domain reset and mode crossing
    // ------------------------------------------------------------
    // Reset is a level; two stages, no logic on the first
    logic lrst_meta_ff;
    logic lrst_n_ff;
    logic mode_meta_ff;
    logic mode_on_ff;

    always_ff @(posedge link_clk) begin
        lrst_meta_ff <= resetn;
        lrst_n_ff <= lrst_meta_ff;
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_n_ff) begin
            mode_meta_ff <= 1'b0;
            mode_on_ff <= 1'b0;
        end else begin
            mode_meta_ff <= dll_locked;
            mode_on_ff <= mode_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Command pipelines, primary rising edge
    // ------------------------------------------------------------
    logic [DW-1:0] mem [0:(1 << MW)-1];
    logic w1_ff, w2_ff, w3_ff;
    logic nxt_w1, nxt_w2, nxt_w3;
    logic [AW-1:0] wa1_ff, wa2_ff, wa3_ff;
    logic [AW-1:0] nxt_wa1, nxt_wa2, nxt_wa3;
    dsp_pkg::dsp_rd_stage_t s1_ff, s2_ff, s3_ff, s4_ff;
    dsp_pkg::dsp_rd_stage_t nxt_s1, nxt_s2, nxt_s3, nxt_s4;
    logic wr_go;
    logic rd_go;
    logic [DW-1:0] pos_q_ff, nxt_pos_q;
    logic pos_v_ff, nxt_pos_v;

    // Spacing keeps a second burst from overlapping a running one
    assign wr_go = !wr_sel_n && !w1_ff;
    assign rd_go = !rd_sel_n && !s1_ff.valid;

    always_comb begin
        nxt_w1 = wr_go;
        nxt_wa1 = wr_go ? addr_in : wa1_ff;
        nxt_w2 = w1_ff;
        nxt_wa2 = wa1_ff;
        nxt_w3 = w2_ff;
        nxt_wa3 = wa2_ff;
        nxt_s1 = dsp_pkg::RD_STAGE_RST;
        if (rd_go) begin
            nxt_s1.valid = 1'b1;
            nxt_s1.dll_on = mode_on_ff;
            for (int k = 0; k < dsp_pkg::BURST_LEN; k++) begin
                nxt_s1.beat[k] = mem[loc(addr_in, 2'(k))];
            end
        end
        nxt_s2 = s1_ff;
        nxt_s3 = s2_ff;
        nxt_s4 = s3_ff;
        // Rising edge beats: b0/b2 without loop, b1/b3 with it
        nxt_pos_v = 1'b1;
        nxt_pos_q = '0;
        if (s1_ff.valid && !s1_ff.dll_on) begin
            nxt_pos_q = s1_ff.beat[0];
        end else if (s2_ff.valid && !s2_ff.dll_on) begin
            nxt_pos_q = s2_ff.beat[2];
        end else if (s3_ff.valid && s3_ff.dll_on) begin
            nxt_pos_q = s3_ff.beat[1];
        end else if (s4_ff.valid && s4_ff.dll_on) begin
            nxt_pos_q = s4_ff.beat[3];
        end else begin
            nxt_pos_v = 1'b0;
        end
        nxt_pos_q = fit(nxt_pos_q);
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_n_ff) begin
            w1_ff <= 1'b0;
            w2_ff <= 1'b0;
            w3_ff <= 1'b0;
            wa1_ff <= '0;
            wa2_ff <= '0;
            wa3_ff <= '0;
            s1_ff <= dsp_pkg::RD_STAGE_RST;
            s2_ff <= dsp_pkg::RD_STAGE_RST;
            s3_ff <= dsp_pkg::RD_STAGE_RST;
            s4_ff <= dsp_pkg::RD_STAGE_RST;
            pos_q_ff <= '0;
            pos_v_ff <= 1'b0;
        end else begin
            w1_ff <= nxt_w1;
            w2_ff <= nxt_w2;
            w3_ff <= nxt_w3;
            wa1_ff <= nxt_wa1;
            wa2_ff <= nxt_wa2;
            wa3_ff <= nxt_wa3;
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
            s3_ff <= nxt_s3;
            s4_ff <= nxt_s4;
            pos_q_ff <= nxt_pos_q;
            pos_v_ff <= nxt_pos_v;
        end
    end

    // ------------------------------------------------------------
    // Complementary edge capture and launch
    // ------------------------------------------------------------
    // The falling edge of the link clock stands in for the rising
    // edge of the complementary clock
    logic [DW-1:0] neg_d_ff, nxt_neg_d;
    logic [dsp_pkg::LANES-1:0] neg_m_ff, nxt_neg_m;
    logic [DW-1:0] neg_q_ff, nxt_neg_q;
    logic neg_v_ff, nxt_neg_v;

    always_comb begin
        nxt_neg_d = wr_data_in;
        nxt_neg_m = byte_mask_n;
        nxt_neg_v = 1'b1;
        nxt_neg_q = '0;
        if (s2_ff.valid && !s2_ff.dll_on) begin
            nxt_neg_q = s2_ff.beat[1];
        end else if (s3_ff.valid && !s3_ff.dll_on) begin
            nxt_neg_q = s3_ff.beat[3];
        end else if (s3_ff.valid && s3_ff.dll_on) begin
            nxt_neg_q = s3_ff.beat[0];
        end else if (s4_ff.valid && s4_ff.dll_on) begin
            nxt_neg_q = s4_ff.beat[2];
        end else begin
            nxt_neg_v = 1'b0;
        end
        nxt_neg_q = fit(nxt_neg_q);
    end

    always_ff @(negedge link_clk) begin
        if (!lrst_n_ff) begin
            neg_d_ff <= '0;
            neg_m_ff <= '1;
            neg_q_ff <= '0;
            neg_v_ff <= 1'b0;
        end else begin
            neg_d_ff <= nxt_neg_d;
            neg_m_ff <= nxt_neg_m;
            neg_q_ff <= nxt_neg_q;
            neg_v_ff <= nxt_neg_v;
        end
    end

    // ------------------------------------------------------------
    // Array writes
    // ------------------------------------------------------------
    // Late write: beats land one, two and three edges after the
    // command; a new burst's first beat may share an edge with the
    // last beat of the previous one
    always_ff @(posedge link_clk) begin
        if (w1_ff) begin
            mem[loc(wa1_ff, 2'd0)] <= merge(mem[loc(wa1_ff, 2'd0)],
                wr_data_in, byte_mask_n);
        end
        if (w2_ff) begin
            mem[loc(wa2_ff, 2'd1)] <= merge(mem[loc(wa2_ff, 2'd1)],
                neg_d_ff, neg_m_ff);
            mem[loc(wa2_ff, 2'd2)] <= merge(mem[loc(wa2_ff, 2'd2)],
                wr_data_in, byte_mask_n);
        end
        if (w3_ff) begin
            mem[loc(wa3_ff, 2'd3)] <= merge(mem[loc(wa3_ff, 2'd3)],
                neg_d_ff, neg_m_ff);
        end
    end

    // ------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------
    // Double rate mux: each half cycle shows the flop of its edge
    assign rd_data_out = link_clk ? pos_q_ff : neg_q_ff;
    assign rd_data_oe = link_clk ? pos_v_ff : neg_v_ff;
    assign out_valid_flag = link_clk ? pos_v_ff : neg_v_ff;
    // Echo clocks follow the link clock, so they never stop
    assign echo_out_clk = link_clk;
    assign echo_out_clk_inv = ~link_clk;

endmodule // dsp_ddr_sram

// File: hw/dsp_pkg.sv
// Operation
// - Address and control sampled on primary rising edge
// - Write data captured on both clock edges
// - Echo clocks toggle continuously, even when idle
// - Echo clock edges align with read data
// - Bypass input low: skip and reset lock
// - Bypass input high: lock after lock time
// - Loop off: read latency one cycle
// - Valid flag marks read data, echo aligned
// - Address ignored when no command selected
// - Narrow mode uses eighteen write bits
// - Narrow mode drives eighteen read bits
// - Read data launched on echo clock edges
// - Read bus driven only for accepted reads
// - Write select low starts a write
// - Read select low starts a read
// - Byte written only where its mask low
// - Loop on: first beat after 2.5 cycles
// - Burst of four, commands every other cycle
package dsp_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 36;
    localparam int NARROW_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int BURST_LEN = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 20;
    localparam int LOCK_TIME_NS = 51200;
    // Least time: round up to whole cycles
    localparam int LOCK_CYCLES = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int LOCK_CNT_W = 16;
    localparam logic [1:0] SYNC_RST = 2'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DLL_BYPASS = 2'b00,
        DLL_LOCKING = 2'b01,
        DLL_LOCKED = 2'b10
    } dsp_dll_state_t;

    typedef struct packed {
        logic valid;
        logic dll_on;
        logic [BURST_LEN-1:0][DATA_W-1:0] beat;
    } dsp_rd_stage_t;

    localparam dsp_rd_stage_t RD_STAGE_RST = '0;

endpackage

// File: sim/dsp_ctl_model.sv
`timescale 1ns/1ns
module dsp_ctl_model (
    // Link clock
    output logic link_clk,
    // Commands
    output logic rd_sel_n,
    output logic wr_sel_n,
    output logic [9:0] addr_in,
    // Write beats
    output logic [35:0] wr_data_in,
    output logic [3:0] byte_mask_n
);
    int hc = 0;
    logic [1:0] cmd_at[int];
    logic [9:0] adr_at[int];
    logic [39:0] dat_at[int];
    initial link_clk = 1'b0;
    initial {rd_sel_n, wr_sel_n, addr_in, wr_data_in, byte_mask_n} = '1;
    // Fall is the complementary edge; 83 MHz also suits bypass
    always #6 link_clk = ~link_clk;
    // --------
    // Edge hc launches slot hc; idle address and data lines toggle so stale values show, idle selects stay high
    // --------
    always @(link_clk) begin
        hc++;
        {rd_sel_n, wr_sel_n} <= cmd_at.exists(hc) ? cmd_at[hc] : 2'b11;
        addr_in <= adr_at.exists(hc) ? adr_at[hc] : ~addr_in;
        {byte_mask_n, wr_data_in} <= dat_at.exists(hc) ? dat_at[hc]
            : ~{byte_mask_n, wr_data_in};
    end
    // Command sampled at rise s+4, write beats at edges s+6 to s+9
    task automatic issue(input logic [1:0] c, input logic [9:0] a,
        input logic [3:0][39:0] b, output int s);
        @(posedge link_clk);
        #1;
        s = hc;
        cmd_at[s+2] = c;
        cmd_at[s+3] = c;
        adr_at[s+2] = a;
        adr_at[s+3] = a;
        for (int i = 0; i < 4 && !c[0]; i++) dat_at[s+5+i] = b[i];
    endtask
endmodule // dsp_ctl_model

// File: sim/dsp_ddr_properties.sv
`timescale 1ns/1ns
module dsp_ddr_chk #(
    parameter int LOCK_CYCLES = dsp_pkg::LOCK_CYCLES
) (
    // Clocks and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic link_clk,
    // Pins watched
    input wire logic dll_bypass_n,
    input wire logic dll_locked,
    input wire logic rd_sel_n,
    input wire logic [dsp_pkg::DATA_W-1:0] rd_data_out,
    input wire logic rd_data_oe,
    input wire logic out_valid_flag,
    input wire logic echo_out_clk,
    input wire logic echo_out_clk_inv
);
    // --------
    // Run length of the bypass pin held high
    // --------
    logic [15:0] hi_ff;
    logic [15:0] nxt_hi;
    always_comb begin
        nxt_hi = hi_ff;
        if (!resetn || !dll_bypass_n) nxt_hi = '0;
        else if (hi_ff != 16'hffff) nxt_hi = hi_ff + 16'h0001;
    end
    always_ff @(posedge clk) begin
        hi_ff <= nxt_hi;
    end
    a_valid_oe:
    assert property (@(link_clk) disable iff (!resetn)
        out_valid_flag == rd_data_oe) else $error("valid flag off data");
    a_echo_pair:
    assert property (@(posedge link_clk) disable iff (!resetn)
        !echo_out_clk && echo_out_clk_inv)
        else $error("echo clocks off link clock");
    a_idle_zero:
    assert property (@(link_clk) disable iff (!resetn)
        !rd_data_oe |-> rd_data_out == '0) else $error("idle bus not 0");
    a_no_cmd:
    assert property (@(posedge link_clk) disable iff (!resetn)
        rd_sel_n [*6] |-> !rd_data_oe) else $error("beat with no read");
    a_byp_lat:
    assert property (@(negedge link_clk) disable iff (!resetn)
        !rd_sel_n && $past(rd_sel_n) && !dll_locked && !$past(dll_locked, 8)
        |-> ##2 rd_data_oe ##1 rd_data_oe) else $error("bypass latency");
    a_dll_lat:
    assert property (@(negedge link_clk) disable iff (!resetn)
        !rd_sel_n && $past(rd_sel_n) && dll_locked && $past(dll_locked, 8)
        |-> ##4 rd_data_oe ##1 rd_data_oe) else $error("loop latency");
    a_lock_time:
    assert property (@(posedge clk) disable iff (!resetn)
        $rose(dll_locked) |-> hi_ff >= 16'(LOCK_CYCLES))
        else $error("lock too early");
    a_lock_bound:
    assert property (@(posedge clk) disable iff (!resetn)
        hi_ff == 16'(LOCK_CYCLES + 8) |-> dll_locked)
        else $error("lock too late");
    a_bypass_drop:
    assert property (@(posedge clk) disable iff (!resetn)
        !dll_bypass_n [*6] |-> !dll_locked) else $error("lock kept");
    c_lock: cover property (@(posedge clk) $rose(dll_locked));
    c_rd_byp: cover property (@(posedge link_clk) !rd_sel_n && !dll_locked);
    c_rd_dll: cover property (@(posedge link_clk) !rd_sel_n && dll_locked);
endmodule // dsp_ddr_chk

bind dsp_ddr_sram dsp_ddr_chk #(.LOCK_CYCLES(LOCK_CYCLES)) chk (
    .clk(clk), .resetn(resetn), .link_clk(link_clk),
    .dll_bypass_n(dll_bypass_n), .dll_locked(dll_locked),
    .rd_sel_n(rd_sel_n), .rd_data_out(rd_data_out),
    .rd_data_oe(rd_data_oe), .out_valid_flag(out_valid_flag),
    .echo_out_clk(echo_out_clk), .echo_out_clk_inv(echo_out_clk_inv));

// File: sim/tb.sv
`timescale 1ns/1ns
module tb;
    localparam int LOCK = 4;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic dll_bypass_n = 1'b0;
    logic dll_locked, link_clk, rd_sel_n, wr_sel_n, rd_data_oe;
    logic out_valid_flag, echo_out_clk, echo_out_clk_inv;
    logic [9:0] addr_in;
    logic [3:0] byte_mask_n;
    logic [35:0] wr_data_in, rd_data_out;
    // Narrow part fed the same stimulus as the wide one
    logic [35:0] q_n;
    logic v_n;
    logic [35:0] mem[int];
    logic [35:0] exp_d[$];
    int exp_e[$];
    int num_errors = 0;
    int cmp_count = 0;
    int n;
    bit loop_on = 1'b0;

    always #25 clk = ~clk;

    dsp_ctl_model m (.link_clk(link_clk), .rd_sel_n(rd_sel_n),
        .wr_sel_n(wr_sel_n), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .byte_mask_n(byte_mask_n));
    dsp_ddr_sram #(.AW(10), .WIDE(1'b1), .LOCK_CYCLES(LOCK)) uut (
        .clk(clk), .resetn(resetn), .dll_bypass_n(dll_bypass_n),
        .dll_locked(dll_locked), .link_clk(link_clk), .rd_sel_n(rd_sel_n),
        .wr_sel_n(wr_sel_n), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .byte_mask_n(byte_mask_n), .rd_data_out(rd_data_out),
        .rd_data_oe(rd_data_oe), .out_valid_flag(out_valid_flag),
        .echo_out_clk(echo_out_clk), .echo_out_clk_inv(echo_out_clk_inv));
    dsp_ddr_sram #(.AW(10), .WIDE(1'b0), .LOCK_CYCLES(LOCK)) uut_n (
        .clk(clk), .resetn(resetn), .dll_bypass_n(dll_bypass_n),
        .dll_locked(), .link_clk(link_clk), .rd_sel_n(rd_sel_n),
        .wr_sel_n(wr_sel_n), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .byte_mask_n(byte_mask_n), .rd_data_out(q_n),
        .rd_data_oe(), .out_valid_flag(v_n),
        .echo_out_clk(), .echo_out_clk_inv());

    task automatic chk_d(string nm, logic [35:0] e, logic [35:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_t(string nm, int e, int g);
        cmp_count++;
        if (g != e) begin
            num_errors++;
            $display("wrong value %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    // --------
    // One command; fm writes all lanes, nx repeats a read next cycle
    // --------
    task automatic op(logic [1:0] c, logic [9:0] a, bit fm, bit nx);
        logic [3:0][39:0] b;
        int s;
        int s2;
        for (int k = 0; k < 4; k++) b[k] = {fm ? 4'h0 : 4'($urandom),
            36'({$urandom, $urandom})};
        m.issue(c, a, b, s);
        for (int k = 0; k < 4 && !c[1]; k++) begin
            exp_e.push_back(s + (loop_on ? 9 : 6) + k);
            exp_d.push_back(mem[a*4+k]);
        end
        for (int k = 0; k < 16 && !c[0]; k++)
            if (!b[k/4][36+k%4]) mem[a*4+k/4][9*(k%4)+:9] = b[k/4][9*(k%4)+:9];
        // Spacing of two cycles; a read repeated sooner must be dropped
        if (nx) m.issue(c, a + 10'h001, b, s2);
        else @(posedge link_clk);
    endtask
    always @(m.hc) begin
        logic [35:0] e;
        #3;
        if (out_valid_flag === 1'b1 && exp_e.size() == 0)
            chk_t("extra beat", -1, m.hc);
        else if (out_valid_flag === 1'b1) begin
            e = exp_d.pop_front();
            chk_t("beat edge", exp_e.pop_front(), m.hc);
            chk_d("beat data", e, rd_data_out);
            chk_t("narrow valid", 1, int'(v_n));
            chk_d("narrow", 36'(e[17:0]), q_n);
        end
    end
    task automatic rd_pass(string nm);
        for (int i = 0; i < 4; i++) op(2'b01, 10'(i), 0, i == 1);
        op(2'b00, 10'h000, 1, 0);
        repeat (12) @(posedge link_clk);
        chk_t("beats left", 0, exp_e.size());
        $display("test %s done", nm);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Whole run needs a few microseconds; this leaves wide margin
    initial begin
        #100000;
        num_errors++;
        results();
    end
    initial begin
        void'($urandom(62935));
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (5) @(posedge link_clk);
        for (int i = 0; i < 8; i++) op(2'b10, 10'(i % 4), i < 4, 0);
        repeat (4) @(posedge link_clk);
        $display("test writes done");
        rd_pass("bypass");
        @(posedge clk);
        dll_bypass_n <= 1'b1;
        n = 0;
        while (dll_locked !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk_t("lock window", 1, int'(n >= LOCK && n <= LOCK + 8));
        $display("test lock done");
        repeat (4) @(posedge clk);
        loop_on = 1'b1;
        rd_pass("loop on");
        @(posedge clk);
        dll_bypass_n <= 1'b0;
        repeat (10) @(posedge clk);
        chk_d("locked flag", 36'h0_0000_0000, 36'(dll_locked));
        loop_on = 1'b0;
        rd_pass("bypass again");
        results();
    end
endmodule // tb
